// *** rtl/tsb_bank.sv ***
/*
  Register bank of the temperature sensor: selector, configuration,
  temperature reading and two limits, plus the end-of-conversion alarm
  and the conversion timer. Byte commands arrive on the link clock from
  an external bus byte engine; registers and alarm live on i_clk.
  Assumes the converter returns i_conv_done on i_clk after o_conv_start.
*/
// Notes on behaviour
// - selector is one byte; only its two low bits pick the register.
// - codes 00 temp, 01 config, 10 hysteresis, 11 overtemp limit.
// - selector latched when its byte executes; reads reuse the last one.
// - selector is zero after reset, so plain reads give temperature.
// - selector itself can never be read back.
// - config bits 7..5 are plain storage, reset zero.
// - config bits 4..3 choose 1, 2, 4 or 6 consecutive faults.
// - config bit 2 sets alarm active level, high when one.
// - config bit 1 selects interrupt style, zero is comparator.
// - config bit 0 stops conversions when set.
// - temperature register is read-only, loaded at conversion end.
// - eleven-bit reading sits left aligned, five low bits zero.
// - temperature read gives high byte then low byte.
// - limits are nine-bit values in the top nine bits, read and write.
// - every conversion end compares the reading with both limits.
// - comparison uses the top nine bits of the reading.
// - comparator style sets above limit, clears below hysteresis only.
// - interrupt style alternates trips; any read or shutdown clears.
// - conversion every 100 ms, at reset release and leaving shutdown.
// - limits reset to 80 and 75 degrees.
`timescale 1ns/100ps
`default_nettype none

module tsb_bank #(
  parameter int CONV_CYCLES = tsb_pkg::CONV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_lk_clk,
  input wire logic i_lk_start,
  input wire logic i_lk_read,
  input wire logic i_lk_wr_vld,
  input wire logic [7:0] i_lk_wr_byte,
  input wire logic i_lk_rd_next,
  output logic [7:0] o_lk_rd_byte,
  output logic o_lk_rd_rdy,
  output logic o_lk_busy,
  input wire logic i_conv_done,
  input wire logic [10:0] i_conv_temp,
  output logic o_conv_start,
  output logic o_shutdown,
  output logic o_alarm_output,
  output logic o_alarm_output_oe
);

  // ****************************************
  // fault depth decode
  // ****************************************
  function automatic logic [2:0] fq_depth(input logic [1:0] code);
    logic [2:0] d;
    unique case (code)
      2'h0: d = tsb_pkg::FQ_DEPTH_0;
      2'h1: d = tsb_pkg::FQ_DEPTH_1;
      2'h2: d = tsb_pkg::FQ_DEPTH_2;
      2'h3: d = tsb_pkg::FQ_DEPTH_3;
    endcase
    return d;
  endfunction : fq_depth

  localparam logic [21:0] TMR_LAST = 22'(CONV_CYCLES - 1);

  // ****************************************
  // link domain
  // ****************************************
  tsb_pkg::tsb_req_s lk_req_r;
  logic lk_req_tgl_r, lk_busy_r, lk_rd_lo_r, lk_rd_rdy_r;
  logic [1:0] lk_widx_r;
  logic [15:0] lk_rd_word_r, rd_word_r;
  logic [7:0] lk_rd_byte_r;
  logic lk_ack_p, lk_issue, lk_issue_rd, lk_issue_wr, ack_tgl_r;

  // a write byte while busy is dropped; busy tells the byte engine to wait
  assign lk_issue_rd = i_lk_start && i_lk_read && !lk_busy_r;
  assign lk_issue_wr = i_lk_wr_vld && !lk_busy_r && (lk_widx_r != 2'h3);
  assign lk_issue = lk_issue_rd || lk_issue_wr;

  tsb_tgl_sync u_ack_sync (
    .i_clk(i_lk_clk),
    .i_rst_n(i_rst_n),
    .i_tgl(ack_tgl_r),
    .o_pulse(lk_ack_p)
  );

  // byte position in a write: selector, high data, low data, then ignored
  always_ff @(posedge i_lk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_widx_r <= 2'h0;
    end else if (i_lk_start) begin
      lk_widx_r <= 2'h0;
    end else if (lk_issue_wr) begin
      lk_widx_r <= lk_widx_r + 2'h1;
    end
  end

  // request word held stable until the core answers
  always_ff @(posedge i_lk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_req_r <= '{kind: tsb_pkg::TSB_REQ_SEL, data: tsb_pkg::BYTE_ZERO};
      lk_req_tgl_r <= 1'b0;
      lk_busy_r <= 1'b0;
    end else begin
      if (lk_issue_rd) begin
        lk_req_r <= '{kind: tsb_pkg::TSB_REQ_RD, data: tsb_pkg::BYTE_ZERO};
      end else if (lk_issue_wr) begin
        lk_req_r.data <= i_lk_wr_byte;
        unique case (lk_widx_r)
          2'h0: lk_req_r.kind <= tsb_pkg::TSB_REQ_SEL;
          2'h1: lk_req_r.kind <= tsb_pkg::TSB_REQ_WHI;
          default: lk_req_r.kind <= tsb_pkg::TSB_REQ_WLO;
        endcase
      end
      if (lk_issue) begin
        lk_req_tgl_r <= ~lk_req_tgl_r;
        lk_busy_r <= 1'b1;
      end else if (lk_ack_p) begin
        lk_busy_r <= 1'b0;
      end
    end
  end

  // read path: word captured after the answer, high byte first
  always_ff @(posedge i_lk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_rd_word_r <= tsb_pkg::TEMP_RESET;
      lk_rd_byte_r <= tsb_pkg::BYTE_ZERO;
      lk_rd_rdy_r <= 1'b0;
      lk_rd_lo_r <= 1'b0;
    end else if (lk_ack_p && lk_req_r.kind == tsb_pkg::TSB_REQ_RD) begin
      lk_rd_word_r <= rd_word_r; // stable: core froze it before acking
      lk_rd_byte_r <= rd_word_r[15:8];
      lk_rd_rdy_r <= 1'b1;
      lk_rd_lo_r <= 1'b1;
    end else if (i_lk_start) begin
      lk_rd_rdy_r <= 1'b0;
    end else if (i_lk_rd_next && lk_rd_rdy_r) begin
      lk_rd_byte_r <= lk_rd_lo_r ? lk_rd_word_r[7:0] : lk_rd_word_r[15:8];
      lk_rd_lo_r <= ~lk_rd_lo_r;
    end
  end

  assign o_lk_rd_byte = lk_rd_byte_r;
  assign o_lk_rd_rdy = lk_rd_rdy_r;
  assign o_lk_busy = lk_busy_r;

  // ****************************************
  // core domain: register file
  // ****************************************
  logic req_p, is_sel, is_whi, is_wlo, is_rd;
  logic [1:0] sel_r;
  logic [7:0] cfg_r, stage_hi_r;
  logic [15:0] temp_r, tos_r, hyst_r;

  tsb_tgl_sync u_req_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tgl(lk_req_tgl_r),
    .o_pulse(req_p)
  );

  // request word is stable here: the link holds it while busy
  assign is_sel = req_p && lk_req_r.kind == tsb_pkg::TSB_REQ_SEL;
  assign is_whi = req_p && lk_req_r.kind == tsb_pkg::TSB_REQ_WHI;
  assign is_wlo = req_p && lk_req_r.kind == tsb_pkg::TSB_REQ_WLO;
  assign is_rd = req_p && lk_req_r.kind == tsb_pkg::TSB_REQ_RD;

  // selector: upper six bits of the byte are dropped, never readable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_r <= tsb_pkg::SEL_RESET;
    end else if (is_sel) begin
      sel_r <= lk_req_r.data[1:0];
    end
  end

  // configuration and limit writes; limit high byte waits for the low one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= tsb_pkg::CFG_RESET;
      tos_r <= tsb_pkg::TOS_RESET;
      hyst_r <= tsb_pkg::HYST_RESET;
      stage_hi_r <= tsb_pkg::BYTE_ZERO;
    end else begin
      if (is_whi && sel_r == tsb_pkg::SEL_CONF) begin
        cfg_r <= lk_req_r.data;
      end
      if (is_whi) begin
        stage_hi_r <= lk_req_r.data;
      end
      if (is_wlo && sel_r == tsb_pkg::SEL_TOS) begin
        tos_r <= {stage_hi_r, lk_req_r.data & tsb_pkg::LIMIT_LO_MASK};
      end
      if (is_wlo && sel_r == tsb_pkg::SEL_HYST) begin
        hyst_r <= {stage_hi_r, lk_req_r.data & tsb_pkg::LIMIT_LO_MASK};
      end
    end
  end

  // read snapshot and answer; config repeats its byte in both halves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_word_r <= tsb_pkg::TEMP_RESET;
      ack_tgl_r <= 1'b0;
    end else if (req_p) begin
      ack_tgl_r <= ~ack_tgl_r;
      if (is_rd) begin
        unique case (sel_r)
          tsb_pkg::SEL_TEMP: rd_word_r <= temp_r;
          tsb_pkg::SEL_CONF: rd_word_r <= {cfg_r, cfg_r};
          tsb_pkg::SEL_HYST: rd_word_r <= hyst_r;
          tsb_pkg::SEL_TOS: rd_word_r <= tos_r;
        endcase
      end
    end
  end

  // ****************************************
  // conversion timer and temperature
  // ****************************************
  logic [21:0] tmr_r;
  logic sd_q_r, conv_start_r, sd_entry, conv_ok;

  assign sd_entry = cfg_r[tsb_pkg::CFG_SHUTDOWN] && !sd_q_r;
  assign conv_ok = i_conv_done && !cfg_r[tsb_pkg::CFG_SHUTDOWN];

  // sd_q resets high so the release looks like leaving shutdown
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_r <= '0;
      sd_q_r <= 1'b1;
      conv_start_r <= 1'b0;
    end else begin
      sd_q_r <= cfg_r[tsb_pkg::CFG_SHUTDOWN];
      conv_start_r <= 1'b0;
      if (cfg_r[tsb_pkg::CFG_SHUTDOWN]) begin
        tmr_r <= '0;
      end else if (sd_q_r || tmr_r == TMR_LAST) begin
        tmr_r <= '0;
        conv_start_r <= 1'b1;
      end else begin
        tmr_r <= tmr_r + 22'h1;
      end
    end
  end

  // results arriving during shutdown are dropped; register keeps the last
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_r <= tsb_pkg::TEMP_RESET;
    end else if (conv_ok) begin
      temp_r <= {i_conv_temp, tsb_pkg::TEMP_PAD};
    end
  end

  // ****************************************
  // alarm
  // ****************************************
  tsb_pkg::tsb_phase_e phase_r;
  logic [2:0] cnt_r;
  logic alm_act_r, oe_r, over, under, trip, hit, style_int;

  assign style_int = cfg_r[tsb_pkg::CFG_STYLE];
  // nine-bit signed compare against the fresh reading
  assign over = $signed(i_conv_temp[10:2]) > $signed(tos_r[15:7]);
  assign under = $signed(i_conv_temp[10:2]) < $signed(hyst_r[15:7]);

  // comparator looks both ways; interrupt only while idle, per phase
  assign trip = !style_int ? (alm_act_r ? under : over) :
                (!alm_act_r && (phase_r == tsb_pkg::TSB_WAIT_OVER ? over : under));

  // consecutive trips; a clean conversion restarts the count
  assign hit = conv_ok && trip && (cnt_r + 3'h1 >= fq_depth(cfg_r[4:3]));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 3'h0;
    end else if (is_whi && sel_r == tsb_pkg::SEL_CONF) begin
      cnt_r <= 3'h0; // a new depth must not inherit a count above it
    end else if (conv_ok) begin
      cnt_r <= (trip && !hit) ? cnt_r + 3'h1 : 3'h0;
    end
  end

  // a trip in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alm_act_r <= 1'b0;
      phase_r <= tsb_pkg::TSB_WAIT_OVER;
    end else if (hit) begin
      alm_act_r <= style_int ? 1'b1 : ~alm_act_r;
      if (style_int) begin
        phase_r <= (phase_r == tsb_pkg::TSB_WAIT_OVER) ?
                   tsb_pkg::TSB_WAIT_UNDER : tsb_pkg::TSB_WAIT_OVER;
      end
    end else if (style_int && (is_rd || sd_entry)) begin
      alm_act_r <= 1'b0;
    end
  end

  // open drain: pull low exactly when the pin level must be low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= alm_act_r ^ cfg_r[tsb_pkg::CFG_POLARITY];
    end
  end

  assign o_alarm_output = 1'b0;
  assign o_alarm_output_oe = oe_r;
  assign o_conv_start = conv_start_r;
  assign o_shutdown = sd_q_r;

  // ****************************************
  // checks
  // ****************************************
  sel_latch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_sel |=> sel_r == $past(lk_req_r.data[1:0]))
    else $error("selector did not take low two bits");
  read_mux_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_rd && sel_r == tsb_pkg::SEL_TOS |=> rd_word_r == tos_r)
    else $error("limit read returned wrong word");
  temp_pad_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    conv_ok |=> temp_r == {$past(i_conv_temp), tsb_pkg::TEMP_PAD})
    else $error("temperature not loaded left aligned");
  limit_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tos_r[6:0] == 7'h00 && hyst_r[6:0] == 7'h00)
    else $error("limit unused bits not zero");
  cfg_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_whi && sel_r == tsb_pkg::SEL_CONF |=> cfg_r == $past(lk_req_r.data))
    else $error("configuration write lost");
  fault_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cnt_r < fq_depth(cfg_r[4:3]) || !$stable(cfg_r))
    else $error("fault count passed its depth");
  comp_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !style_int && !conv_ok ##1 !style_int |-> $stable(alm_act_r))
    else $error("comparator alarm moved without conversion");
  int_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    style_int && is_rd && !conv_ok |=> !alm_act_r)
    else $error("interrupt alarm not cleared by read");
  conv_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv_start && !cfg_r[tsb_pkg::CFG_SHUTDOWN] |=> !o_conv_start [*2])
    else $error("conversion starts too close");
  // pin flop lags one edge, so compare only once inputs have settled
  pin_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $stable(alm_act_r) && $stable(cfg_r) |->
    o_alarm_output_oe == (alm_act_r ^ cfg_r[tsb_pkg::CFG_POLARITY]))
    else $error("alarm pin level wrong");
  rd_high_a: assert property (@(posedge i_lk_clk) disable iff (!i_rst_n)
    lk_ack_p && lk_req_r.kind == tsb_pkg::TSB_REQ_RD |=>
    o_lk_rd_rdy && o_lk_rd_byte == lk_rd_word_r[15:8])
    else $error("read did not start with high byte");

  alarm_set_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !style_int && hit && !alm_act_r);
  int_clear_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    style_int && alm_act_r && is_rd);
  sd_entry_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    sd_entry);
  read_done_c: cover property (@(posedge i_lk_clk) disable iff (!i_rst_n)
    o_lk_rd_rdy && i_lk_rd_next);

endmodule : tsb_bank

`default_nettype wire

// *** rtl/tsb_pkg.sv ***
/*
  Shared constants and types of the temperature sensor register bank:
  selector codes, configuration field positions, reset values, conversion
  timing and the request word that carries bus commands between domains.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tsb_pkg;

  // ****************************************
  // selector codes
  // ****************************************
  localparam logic [1:0] SEL_TEMP = 2'h0;
  localparam logic [1:0] SEL_CONF = 2'h1;
  localparam logic [1:0] SEL_HYST = 2'h2;
  localparam logic [1:0] SEL_TOS = 2'h3;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // ****************************************
  // configuration fields
  // ****************************************
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_STYLE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_FQ_LO = 3;
  localparam int CFG_FQ_HI = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ****************************************
  // data layouts and reset values
  // ****************************************
  localparam logic [15:0] TOS_RESET = 16'h5000;
  localparam logic [15:0] HYST_RESET = 16'h4B00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [7:0] LIMIT_LO_MASK = 8'h80;
  localparam logic [4:0] TEMP_PAD = 5'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // fault queue depths for codes 0..3
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam int CONV_PERIOD_MS = 100;
  localparam int CONV_CYCLES = (CLK_HZ / 1000) * CONV_PERIOD_MS;

  // ****************************************
  // cross-domain request word
  // ****************************************
  typedef enum logic [1:0] {
    TSB_REQ_SEL,
    TSB_REQ_WHI,
    TSB_REQ_WLO,
    TSB_REQ_RD
  } tsb_kind_e;

  typedef struct packed {
    tsb_kind_e kind;
    logic [7:0] data;
  } tsb_req_s;

  typedef enum logic {
    TSB_WAIT_OVER,
    TSB_WAIT_UNDER
  } tsb_phase_e;

endpackage : tsb_pkg

// *** rtl/tsb_tgl_sync.sv ***
/*
  Toggle synchroniser: carries an event from another clock domain as a
  level change and turns it into a one-cycle pulse in the local domain.
  Assumes the source toggles no faster than three local clock periods.
*/
`timescale 1ns/100ps
`default_nettype none

module tsb_tgl_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tgl,
  output logic o_pulse
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // first stage feeds only the second; edge detect looks at later stages
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= i_tgl;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_pulse = sync_r ^ last_r;

endmodule : tsb_tgl_sync

`default_nettype wire

// *** verification/tsb_bank_test.sv ***
/*
  Self-checking bench of the register bank: register rows, then fault
  count, limit boundaries, polarity, interrupt style and shutdown.
  Assumes tsb_link_ctl on the link and a plain converter model here.
*/
`timescale 1ns/100ps
`default_nettype none

module tsb_bank_test;
  localparam int CONV = 50;
  localparam logic [10:0] COLD = 11'h09C;
  localparam logic [10:0] HOT = 11'h0D0;
  typedef struct packed {
    logic [7:0] sel;
    logic [1:0] nb;
    logic [15:0] wd;
    logic [15:0] ex;
  } tsb_row_s;
  logic i_clk, i_rst_n, lk_clk, lk_start, lk_read, wr_vld, rd_next, rd_rdy, busy;
  logic conv_done, conv_start, shutdown, alarm, alarm_oe;
  logic [7:0] wr_byte, rd_byte;
  logic [10:0] conv_temp, cur_temp;
  logic [15:0] v;
  int failures, checks_done, cycles, n;
  int dep[4] = '{1, 2, 4, 6};
  tsb_row_s rows[10] = '{
    '{8'h03, 2'h0, 16'h0000, 16'h5000}, '{8'h02, 2'h0, 16'h0000, 16'h4B00},
    '{8'h01, 2'h0, 16'h0000, 16'h0000}, '{8'h03, 2'h2, 16'h7FFF, 16'h7F80},
    '{8'h02, 2'h2, 16'hCED5, 16'hCE80}, '{8'h01, 2'h1, 16'hE0FF, 16'hE0E0},
    '{8'h00, 2'h2, 16'h1234, 16'hC920}, '{8'h03, 2'h2, 16'h1900, 16'h1900},
    '{8'h02, 2'h2, 16'h1400, 16'h1400}, '{8'h01, 2'h1, 16'h00FF, 16'h0000}};

  tsb_bank #(.CONV_CYCLES(CONV)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_lk_clk(lk_clk), .i_lk_start(lk_start),
    .i_lk_read(lk_read), .i_lk_wr_vld(wr_vld), .i_lk_wr_byte(wr_byte),
    .i_lk_rd_next(rd_next), .o_lk_rd_byte(rd_byte), .o_lk_rd_rdy(rd_rdy),
    .o_lk_busy(busy), .i_conv_done(conv_done), .i_conv_temp(conv_temp),
    .o_conv_start(conv_start), .o_shutdown(shutdown), .o_alarm_output(alarm),
    .o_alarm_output_oe(alarm_oe));

  tsb_link_ctl ctl (
    .o_lk_clk(lk_clk), .o_lk_start(lk_start), .o_lk_read(lk_read),
    .o_lk_wr_vld(wr_vld), .o_lk_wr_byte(wr_byte), .o_lk_rd_next(rd_next),
    .i_lk_rd_byte(rd_byte), .i_lk_rd_rdy(rd_rdy), .i_lk_busy(busy));

  // ********
  // clock, converter and time limit
  // ********
  // core clock 25 MHz
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // converter answers three cycles after each start; result released after
  always begin
    @(posedge i_clk);
    #1;
    if (conv_start === 1'b1) begin
      repeat (3) @(posedge i_clk);
      #1;
      conv_done = 1'b1;
      conv_temp = cur_temp;
      @(posedge i_clk);
      #1;
      conv_done = 1'b0;
      conv_temp = ~cur_temp;
    end
  end

  // a hang counts as a failure and ends the run
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ********
  // helpers
  // ********
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  task automatic wait_conv(input int k);
    repeat (k) @(posedge conv_done);
    repeat (3) @(posedge i_clk);
    #2;
  endtask : wait_conv

  // high enable pulls the open-drain pin low
  task automatic pin(input logic e);
    repeat (3) @(posedge i_clk);
    #2;
    chk("alarm pin enable", {15'h0, e}, {15'h0, alarm_oe});
    chk("alarm pin data", 16'h0000, {15'h0, alarm});
  endtask : pin

  task automatic setcfg(input logic [7:0] c);
    ctl.write_reg(8'h01, 2'h1, {c, 8'h00});
  endtask : setcfg

  // link clock runs through reset so both domains see it
  task automatic do_reset();
    ctl.run = 1'b1;
    i_rst_n = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    ctl.run = 1'b0;
  endtask : do_reset

  // cycles until the next conversion start, 200 when none comes
  task automatic find_start(output int k);
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (conv_start !== 1'b1 && k < 200);
  endtask : find_start

  task automatic stop_test();
    if (ctl.lost != 0) failures++;
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ********
  // main sequence
  // ********
  initial begin
    i_rst_n = 1'b0;
    conv_done = 1'b0;
    conv_temp = 11'h000;
    cur_temp = 11'h649;
    do_reset();
    wait_conv(1);
    ctl.read_reg(8'h00, 1'b0, v);
    chk("plain read", 16'hC920, v);
    foreach (rows[i]) begin
      ctl.gap = (i % 2) * 4;
      if (rows[i].nb != 2'h0) ctl.write_reg(rows[i].sel, rows[i].nb, rows[i].wd);
      ctl.read_reg(rows[i].sel, rows[i].nb == 2'h0, v);
      chk("register row", rows[i].ex, v);
    end
    ctl.gap = 0;
    // every fault count code, comparator style, active low
    for (int c = 0; c < 4; c++) begin
      setcfg({3'h0, c[1:0], 3'h0});
      cur_temp = COLD;
      wait_conv(7);
      pin(1'b0);
      cur_temp = HOT;
      if (dep[c] > 1) begin
        wait_conv(dep[c] - 1);
        pin(1'b0);
      end
      wait_conv(1);
      pin(1'b1);
    end
    setcfg(8'h00);
    ctl.read_reg(8'h00, 1'b1, v);
    chk("hot reading", 16'h1A00, v);
    pin(1'b1);
    cur_temp = 11'h0A3;
    wait_conv(2);
    pin(1'b1);
    cur_temp = COLD;
    wait_conv(1);
    pin(1'b0);
    cur_temp = 11'h0CB;
    wait_conv(2);
    pin(1'b0);
    setcfg(8'h04);
    pin(1'b1);
    cur_temp = HOT;
    wait_conv(1);
    pin(1'b0);
    // interrupt style from a fresh reset in mid-run
    cur_temp = COLD;
    do_reset();
    wait_conv(1);
    ctl.write_reg(8'h03, 2'h2, 16'h1900);
    ctl.write_reg(8'h02, 2'h2, 16'h1400);
    setcfg(8'h02);
    wait_conv(2);
    pin(1'b0);
    cur_temp = HOT;
    wait_conv(2);
    pin(1'b1);
    ctl.read_reg(8'h02, 1'b1, v);
    chk("limit readback", 16'h1400, v);
    pin(1'b0);
    wait_conv(2);
    pin(1'b0);
    cur_temp = COLD;
    wait_conv(1);
    pin(1'b1);
    ctl.read_reg(8'h02, 1'b0, v);
    chk("limit reread", 16'h1400, v);
    pin(1'b0);
    cur_temp = HOT;
    wait_conv(1);
    pin(1'b1);
    setcfg(8'h03);
    pin(1'b0);
    chk("shutdown level", 16'h0001, {15'h0, shutdown});
    find_start(n);
    chk("starts in shutdown", 16'h00C8, n[15:0]);
    setcfg(8'h02);
    find_start(n);
    find_start(n);
    chk("conversion period", CONV[15:0], n[15:0]);
    stop_test();
  end
endmodule : tsb_bank_test

`default_nettype wire

// *** verification/tsb_link_ctl.sv ***
/*
  Bus controller model at the byte level of the link: makes the link
  clock inside frames and while the bench holds reset, and runs register writes and reads.
  Assumes the bank's busy and read-ready handshake on the link clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tsb_link_ctl (
  output logic o_lk_clk,
  output logic o_lk_start,
  output logic o_lk_read,
  output logic o_lk_wr_vld,
  output logic [7:0] o_lk_wr_byte,
  output logic o_lk_rd_next,
  input wire logic [7:0] i_lk_rd_byte,
  input wire logic i_lk_rd_rdy,
  input wire logic i_lk_busy
);
  logic run = 1'b0;
  int gap = 0;
  int lost = 0;

  // ********
  // link clock
  // ********
  // stands low between frames except while the bench runs it through reset; odd offset keeps it unrelated to i_clk
  initial begin
    o_lk_clk = 1'b0;
    o_lk_start = 1'b0;
    o_lk_read = 1'b0;
    o_lk_wr_vld = 1'b0;
    o_lk_wr_byte = 8'h00;
    o_lk_rd_next = 1'b0;
    #1.3;
    forever begin
      #3;
      if (run || o_lk_clk) begin
        o_lk_clk = ~o_lk_clk;
      end
    end
  end

  // ********
  // transfers
  // ********
  task automatic step();
    @(posedge o_lk_clk);
    #1;
  endtask : step

  // one start or byte; waits out busy so nothing lands in a refusal
  task automatic put(input logic [7:0] b, input logic s, input logic r);
    int k;
    o_lk_start = s;
    o_lk_read = r;
    o_lk_wr_vld = ~s;
    o_lk_wr_byte = b;
    step();
    o_lk_start = 1'b0;
    o_lk_read = 1'b0;
    o_lk_wr_vld = 1'b0;
    o_lk_wr_byte = ~b; // released byte never shows the stale value
    step(); // idle edge keeps the next request out of this time step
    if (!s || r) begin
      for (k = 0; k < 100 && i_lk_busy !== 1'b0; k++) begin
        step();
      end
      if (k == 100) begin
        lost++;
      end
      repeat (gap) step(); // slow controller when gap is set
    end
  endtask : put

  // selector, then up to two data bytes, high byte first
  task automatic write_reg(input logic [7:0] sel, input logic [1:0] n, input logic [15:0] d);
    run = 1'b1;
    repeat (3) step();
    put(8'h00, 1'b1, 1'b0);
    put(sel, 1'b0, 1'b0);
    if (n > 2'h0) put(d[15:8], 1'b0, 1'b0);
    if (n > 2'h1) put(d[7:0], 1'b0, 1'b0);
    repeat (2) step();
    run = 1'b0;
  endtask : write_reg

  // reselects only when asked, then collects both bytes
  task automatic read_reg(input logic [7:0] sel, input logic resel, output logic [15:0] v);
    if (resel) write_reg(sel, 2'h0, 16'h0000);
    run = 1'b1;
    repeat (3) step();
    put(8'h00, 1'b1, 1'b1);
    v[15:8] = i_lk_rd_rdy ? i_lk_rd_byte : 8'hXX;
    o_lk_rd_next = 1'b1;
    step();
    o_lk_rd_next = 1'b0;
    v[7:0] = i_lk_rd_byte;
    repeat (2) step();
    run = 1'b0;
  endtask : read_reg
endmodule : tsb_link_ctl

`default_nettype wire
